// ---- logic/ssbc_defs.svh ----
`ifndef SSBC_DEFS_SVH
`define SSBC_DEFS_SVH

// Array shape
`define SSBC_ADDR_W 18
`define SSBC_LANES 4
`define SSBC_LANE_W 9

// Register map
`define SSBC_APB_AW 8
`define SSBC_CTRL_OFS 8'h00
`define SSBC_STAT_OFS 8'h04
`define SSBC_CTRL_EN_BIT 0
`define SSBC_CTRL_RST 1'b1

// Status fields
`define SSBC_ST_BURST_LO 0
`define SSBC_ST_ACTIVE 2
`define SSBC_ST_PIPE 3
`define SSBC_ST_ILV 4
`define SSBC_ST_SLEEP 5
`define SSBC_ST_TIELOW 6
`define SSBC_ST_DRIVE 7
`define SSBC_ST_W 8

`endif

// ---- logic/ssbc_pkg.sv ----
package ssbc_pkg;
	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_DESEL,
		CMD_BEGIN_RD,
		CMD_BEGIN_WR,
		CMD_CONT,
		CMD_SUSP
	} ssbc_cmd_t;
endpackage : ssbc_pkg

// ---- logic/ssbc_burst_ctr.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbc_burst_ctr import ssbc_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_load,
	input wire logic [1:0] i_preset,
	input wire logic i_advance,
	input wire logic i_interleave,
	output logic [1:0] o_cur,
	output logic [1:0] o_next,
	output logic [1:0] o_start
);
	logic [1:0] start_r;
	logic [1:0] cnt_r;

	// Address for a given count in either order
	function automatic logic [1:0] seq_addr(input logic [1:0] start, input logic [1:0] cnt,
		input logic ilv);
		seq_addr = ilv ? (start ^ cnt) : 2'(start + cnt);
	endfunction : seq_addr

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			start_r <= 2'h0;
			cnt_r <= 2'h0;
		end else if (i_load) begin
			start_r <= i_preset;
			cnt_r <= 2'h0;
		end else if (i_advance) begin
			cnt_r <= 2'(cnt_r + 2'h1);
		end
	end

	assign o_cur = seq_addr(start_r, cnt_r, i_interleave);
	assign o_next = seq_addr(start_r, 2'(cnt_r + 2'h1), i_interleave);
	assign o_start = start_r;
endmodule : ssbc_burst_ctr
`default_nettype wire

// ---- logic/ssbc_apb_regs.sv ----
`include "ssbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbc_apb_regs import ssbc_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`SSBC_APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [`SSBC_ST_W-1:0] i_status,
	output logic o_enable
);
	logic ctrl_en_r;
	logic [31:0] prdata_r;
	logic slverr_r;
	logic setup;
	logic access;

	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_en_r <= `SSBC_CTRL_RST;
		end else if (access && i_pwrite && i_paddr == `SSBC_CTRL_OFS) begin
			ctrl_en_r <= i_pwdata[`SSBC_CTRL_EN_BIT];
		end
	end

	// Read data and error are set up ahead of the access phase
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			prdata_r <= 32'h0;
			slverr_r <= 1'b0;
		end else if (setup) begin
			case (i_paddr)
				`SSBC_CTRL_OFS: begin
					prdata_r <= {31'h0, ctrl_en_r};
					slverr_r <= 1'b0;
				end
				`SSBC_STAT_OFS: begin
					prdata_r <= {{(32-`SSBC_ST_W){1'b0}}, i_status};
					slverr_r <= 1'b0;
				end
				default: begin
					prdata_r <= 32'h0;
					slverr_r <= 1'b1;
				end
			endcase
		end
	end

	assign o_prdata = prdata_r;
	assign o_pready = 1'b1;
	assign o_pslverr = slverr_r & access;
	assign o_enable = ctrl_en_r;
endmodule : ssbc_apb_regs
`default_nettype wire

// ---- logic/ssbc_sram.sv ----
`include "ssbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssbc_sram import ssbc_pkg::*; #(
	parameter int ADDR_W = `SSBC_ADDR_W,
	parameter int LANES = `SSBC_LANES,
	parameter int LANE_W = `SSBC_LANE_W
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [LANES*LANE_W-1:0] i_dq,
	output logic [LANES*LANE_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic i_chip_sel_first_n,
	input wire logic i_chip_sel_second,
	input wire logic i_chip_sel_third_n,
	input wire logic i_proc_addr_strobe_n,
	input wire logic i_ctrl_addr_strobe_n,
	input wire logic i_burst_advance_n,
	input wire logic i_global_write_n,
	input wire logic i_byte_write_n,
	input wire logic i_lane_a_write_n,
	input wire logic i_lane_b_write_n,
	input wire logic i_lane_c_write_n,
	input wire logic i_lane_d_write_n,
	input wire logic i_out_en_n,
	input wire logic i_sleep_req,
	input wire logic i_sleep_drv,
	input wire logic i_flowthru_strap_n,
	input wire logic i_flowthru_strap_drv,
	input wire logic i_linear_order_strap_n,
	input wire logic i_tie_low_input,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`SSBC_APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 2 ** ADDR_W;

	logic [DATA_W-1:0] mem [0:DEPTH-1];
	logic [LANES-1:0] lane_n;
	logic [LANES-1:0] wr_mask;
	logic is_write;
	logic sleep_eff;
	logic pipe_mode;
	logic ilv_mode;
	logic sw_enable;
	logic chip_sel;
	ssbc_cmd_t cmd;
	logic load_go;
	logic adv_go;
	logic is_rd_op;
	logic is_wr_op;
	logic [ADDR_W-1:0] use_addr;
	logic [ADDR_W-3:0] upper_r;
	logic active_r;
	logic [1:0] bur_cur;
	logic [1:0] bur_next;
	logic [1:0] bur_start;
	logic [DATA_W-1:0] ft_data_r;
	logic [DATA_W-1:0] pl_data_r;
	logic v1_r;
	logic v2_r;
	logic drive;
	logic [DATA_W-1:0] old_word_r;
	logic [`SSBC_ST_W-1:0] status;

	// Floating flow-through strap and sleep pins resolve to their pull levels
	assign pipe_mode = i_flowthru_strap_drv ? i_flowthru_strap_n : 1'b1;
	assign sleep_eff = i_sleep_drv ? i_sleep_req : 1'b0;
	assign ilv_mode = i_linear_order_strap_n;

	assign chip_sel = ~i_chip_sel_first_n & i_chip_sel_second & ~i_chip_sel_third_n
		& sw_enable;

	// Lane enables; parity bit is the top bit of each lane
	assign lane_n = {i_lane_d_write_n, i_lane_c_write_n, i_lane_b_write_n, i_lane_a_write_n};
	assign is_write = ~i_global_write_n | ~i_byte_write_n;

	always_comb begin
		if (!i_global_write_n) begin
			wr_mask = {LANES{1'b1}};
		end else if (!i_byte_write_n) begin
			wr_mask = ~lane_n;
		end else begin
			wr_mask = {LANES{1'b0}};
		end
	end

	// Command from strobes, enables and burst state
	function automatic ssbc_cmd_t decode(input logic e1_n, input logic sel,
		input logic proc_addr_strobe_n_n, input logic ctrl_addr_strobe_n_n, input logic adv_n,
		input logic wr, input logic active);
		if (!proc_addr_strobe_n_n && !e1_n) begin
			decode = sel ? CMD_BEGIN_RD : CMD_DESEL;
		end else if (!ctrl_addr_strobe_n_n) begin
			decode = sel ? (wr ? CMD_BEGIN_WR : CMD_BEGIN_RD) : CMD_DESEL;
		end else if (!active) begin
			decode = CMD_IDLE;
		end else if (!adv_n) begin
			decode = CMD_CONT;
		end else begin
			decode = CMD_SUSP;
		end
	endfunction : decode

	assign cmd = sleep_eff ? CMD_IDLE : decode(i_chip_sel_first_n, chip_sel,
		i_proc_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_advance_n, is_write,
		active_r & sw_enable);

	assign load_go = (cmd == CMD_BEGIN_RD) || (cmd == CMD_BEGIN_WR);
	assign adv_go = (cmd == CMD_CONT);
	assign is_rd_op = (cmd == CMD_BEGIN_RD)
		|| (((cmd == CMD_CONT) || (cmd == CMD_SUSP)) && !is_write);
	assign is_wr_op = (cmd == CMD_BEGIN_WR)
		|| (((cmd == CMD_CONT) || (cmd == CMD_SUSP)) && is_write);

	always_comb begin
		case (cmd)
			CMD_BEGIN_RD: use_addr = i_addr;
			CMD_BEGIN_WR: use_addr = i_addr;
			CMD_CONT: use_addr = {upper_r, bur_next};
			default: use_addr = {upper_r, bur_cur};
		endcase
	end

	ssbc_burst_ctr u_ctr (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_load(load_go),
		.i_preset(i_addr[1:0]),
		.i_advance(adv_go),
		.i_interleave(ilv_mode),
		.o_cur(bur_cur),
		.o_next(bur_next),
		.o_start(bur_start)
	);

	// Upper address and burst activity
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			upper_r <= '0;
		end else if (load_go) begin
			upper_r <= i_addr[ADDR_W-1:2];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			active_r <= 1'b0;
		end else if (!sw_enable || cmd == CMD_DESEL) begin
			active_r <= 1'b0;
		end else if (load_go) begin
			active_r <= 1'b1;
		end
	end

	// Array write, per lane; contents untouched in sleep
	always_ff @(posedge i_clk_sys) begin
		for (int l = 0; l < LANES; l++) begin
			if (is_wr_op && wr_mask[l]) begin
				mem[use_addr][l*LANE_W +: LANE_W] <= i_dq[l*LANE_W +: LANE_W];
			end
		end
	end

	// Read path: first stage is the flow-through output
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ft_data_r <= '0;
			v1_r <= 1'b0;
		end else begin
			v1_r <= is_rd_op;
			if (is_rd_op) begin
				ft_data_r <= mem[use_addr];
			end
		end
	end

	// Output register stage for pipelined mode, deselect delayed alike
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pl_data_r <= '0;
			v2_r <= 1'b0;
		end else begin
			pl_data_r <= ft_data_r;
			v2_r <= v1_r;
		end
	end

	assign drive = pipe_mode ? v2_r : v1_r;
	assign o_dq = pipe_mode ? pl_data_r : ft_data_r;
	assign o_dq_oe = drive & ~i_out_en_n & ~sleep_eff;

	// Pre-write word, kept for checking lane isolation
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			old_word_r <= '0;
		end else begin
			old_word_r <= mem[use_addr];
		end
	end

	// Status seen by software; tie-low level shows misuse of that input
	always_comb begin
		status = '0;
		status[`SSBC_ST_BURST_LO +: 2] = bur_cur;
		status[`SSBC_ST_ACTIVE] = active_r;
		status[`SSBC_ST_PIPE] = pipe_mode;
		status[`SSBC_ST_ILV] = ilv_mode;
		status[`SSBC_ST_SLEEP] = sleep_eff;
		status[`SSBC_ST_TIELOW] = i_tie_low_input;
		status[`SSBC_ST_DRIVE] = o_dq_oe;
	end

	ssbc_apb_regs u_regs (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_pwdata(i_pwdata),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.i_status(status),
		.o_enable(sw_enable)
	);

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	property p_sel;
		(!chip_sel && !i_ctrl_addr_strobe_n && !sleep_eff) |=> (!active_r && !v1_r);
	endproperty
	a_sel: assert property (p_sel) else $error("unselected strobe started a cycle");

	property p_preset;
		load_go |=> (bur_cur == $past(i_addr[1:0])) && (bur_start == $past(i_addr[1:0]));
	endproperty
	a_preset: assert property (p_preset) else $error("burst preset not loaded");

	property p_strobe;
		(!i_proc_addr_strobe_n && !i_chip_sel_first_n && chip_sel && !sleep_eff)
			|=> (active_r && upper_r == $past(i_addr[ADDR_W-1:2]));
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe did not load address");

	property p_hold;
		(!adv_go && !load_go) ##1 $stable(ilv_mode) |-> $stable(bur_cur);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved without advance");

	property p_lin;
		(adv_go && !ilv_mode) ##1 !ilv_mode |-> (bur_cur == 2'($past(bur_cur) + 2'h1));
	endproperty
	a_lin: assert property (p_lin) else $error("linear step wrong");

	property p_ilv;
		(adv_go && ilv_mode) ##1 ilv_mode
			|-> ((bur_cur ^ bur_start) == 2'($past(bur_cur ^ bur_start) + 2'h1));
	endproperty
	a_ilv: assert property (p_ilv) else $error("interleaved step wrong");

	sequence s_load;
		load_go;
	endsequence
	sequence s_four_adv;
		adv_go [*4];
	endsequence
	property p_wrap;
		s_load ##1 s_four_adv |=> (bur_cur == bur_start);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst did not wrap");

	property p_gwrite;
		(is_wr_op && !i_global_write_n) |=> (mem[$past(use_addr)] == $past(i_dq));
	endproperty
	a_gwrite: assert property (p_gwrite) else $error("global write missed a lane");

	for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
		property p_lane;
			(is_wr_op && i_global_write_n) |=> (mem[$past(use_addr)][g*LANE_W +: LANE_W]
				== ($past(wr_mask[g]) ? $past(i_dq[g*LANE_W +: LANE_W])
				: old_word_r[g*LANE_W +: LANE_W]));
		endproperty
		a_lane: assert property (p_lane) else $error("lane write mask wrong");
	end

	property p_oe;
		i_out_en_n |-> !o_dq_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("driving with output enable high");

	sequence s_ft_read;
		(is_rd_op && !pipe_mode) ##1 (!pipe_mode && !i_out_en_n && !sleep_eff);
	endsequence
	property p_flow;
		s_ft_read |-> o_dq_oe;
	endproperty
	a_flow: assert property (p_flow) else $error("flow-through data late");

	sequence s_pl_read;
		(is_rd_op && pipe_mode) ##1 (pipe_mode && !is_rd_op)
			##1 (pipe_mode && !i_out_en_n && !sleep_eff);
	endsequence
	property p_pipe;
		s_pl_read |-> o_dq_oe;
	endproperty
	a_pipe: assert property (p_pipe) else $error("pipelined data not shown");

	property p_dcd;
		(cmd == CMD_DESEL && pipe_mode) ##1 pipe_mode |=> !o_dq_oe;
	endproperty
	a_dcd: assert property (p_dcd) else $error("deselect did not turn drivers off");

	property p_sleep;
		sleep_eff |-> (!o_dq_oe ##1 ($stable(bur_cur) && $stable(active_r)));
	endproperty
	a_sleep: assert property (p_sleep) else $error("activity during sleep");
endmodule : ssbc_sram
`default_nettype wire

// ---- test/ssbc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbc_host (
	input wire logic i_clk_sys,
	output logic [17:0] o_addr,
	output logic [35:0] o_dq,
	output logic [2:0] o_sel,
	output logic [2:0] o_strb,
	output logic [5:0] o_wr
);
	initial begin
		o_addr = '0;
		o_dq = '0;
		o_sel = 3'h6;
		o_strb = 3'h7;
		o_wr = 6'h3f;
	end
	// One bus cycle, changed just after the edge
	task cyc(input logic [2:0] s, input logic [2:0] sel, input logic [5:0] w,
		input logic [1:0] lo, input logic [35:0] d);
		@(posedge i_clk_sys);
		o_strb <= s;
		o_sel <= sel;
		o_wr <= w;
		o_addr <= {16'h0123, lo};
		o_dq <= (w[5] & w[4]) ? ~o_dq : d; // Released lines toggle
	endtask : cyc
endmodule : ssbc_host
`default_nettype wire

// ---- test/ssbc_sram_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbc_sram_test;
	localparam logic [2:0] BEG_C = 3'h5, BEG_P = 3'h3, CONT = 3'h6, SUSP = 3'h7, SEL = 3'h2;
	localparam logic [5:0] WNONE = 6'h3f, WG = 6'h1f;
	logic clk = 1'b0, nrst = 1'b0;
	logic oe_n = 1'b0, slp = 1'b0, slp_drv = 1'b1, ft_n = 1'b1, ft_drv = 1'b1, lbo_n = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [35:0] pat_d = 36'h987654321;
	logic [35:0] mem [4];
	wire logic [31:0] prd;
	wire logic prdy, perr, dq_oe;
	wire logic [17:0] addr;
	wire logic [35:0] hdq, dq;
	wire logic [2:0] strb, sel;
	wire logic [5:0] wr;
	int fails = 0, checked = 0;
	always #12.5 clk = ~clk;
	ssbc_host u_host (.i_clk_sys(clk), .o_addr(addr), .o_dq(hdq), .o_sel(sel), .o_strb(strb),
		.o_wr(wr));
	ssbc_sram u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_dq(hdq), .o_dq(dq),
		.o_dq_oe(dq_oe), .i_chip_sel_first_n(sel[2]), .i_chip_sel_second(sel[1]),
		.i_chip_sel_third_n(sel[0]), .i_proc_addr_strobe_n(strb[2]),
		.i_ctrl_addr_strobe_n(strb[1]), .i_burst_advance_n(strb[0]), .i_global_write_n(wr[5]),
		.i_byte_write_n(wr[4]), .i_lane_a_write_n(wr[0]), .i_lane_b_write_n(wr[1]),
		.i_lane_c_write_n(wr[2]), .i_lane_d_write_n(wr[3]), .i_out_en_n(oe_n), .i_sleep_req(slp),
		.i_sleep_drv(slp_drv), .i_flowthru_strap_n(ft_n), .i_flowthru_strap_drv(ft_drv),
		.i_linear_order_strap_n(lbo_n), .i_tie_low_input(1'b0), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(perr));
	task conclude;
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1)
			@(posedge clk);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task t_reg;
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(36'(r), 36'h8);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk(36'({e, r}), 36'h100000000);
		apb(1'b1, 8'h00, 32'h0, r, e);
		u_host.cyc(BEG_C, SEL, WNONE, 2'h0, 36'h0);
		repeat (2) u_host.cyc(SUSP, SEL, WNONE, 2'h0, 36'h0);
		#1 chk(36'(dq_oe), 36'h0);
		apb(1'b1, 8'h00, 32'h1, r, e);
		apb(1'b0, 8'h00, 32'h0, r, e);
		chk(36'(r), 36'h1);
	endtask : t_reg
	task wr_burst(input logic [1:0] st, input logic ilv, input logic [5:0] w, input int n);
		logic [1:0] a;
		@(posedge clk);
		lbo_n <= ilv;
		for (int k = 0; k < n; k++) begin
			a = ilv ? st ^ 2'(k) : st + 2'(k);
			pat_d = {pat_d[34:0], pat_d[35]} ^ 36'h10f0f0f0f;
			u_host.cyc(k == 0 ? BEG_C : CONT, SEL, w, st, pat_d);
			for (int l = 0; l < 4; l++)
				if (!w[5] || (!w[4] && !w[l]))
					mem[a][9*l +: 9] = pat_d[9*l +: 9];
		end
		u_host.cyc(BEG_C, 3'h6, WNONE, st, 36'h0);
	endtask : wr_burst
	task t_read(input logic [1:0] st, input logic ilv, input logic pipe, input logic [2:0] bg);
		int lat;
		logic [1:0] a;
		lat = pipe ? 2 : 1;
		@(posedge clk);
		ft_n <= 1'b0;
		ft_drv <= ~pipe;
		lbo_n <= ilv;
		for (int i = 0; i < 8; i++) begin
			u_host.cyc(i == 0 ? bg : (i < 5 ? CONT : (i == 5 ? BEG_C : SUSP)),
				i == 5 ? 3'h6 : SEL, WNONE, st, 36'h0);
			#1;
			a = ilv ? st ^ 2'(i - lat) : st + 2'(i - lat);
			if (i >= lat && i - lat <= 4) begin
				chk(dq, mem[a]);
				chk(36'(dq_oe), 36'h1);
			end
		end
		chk(36'(dq_oe), 36'h0);
	endtask : t_read
	task t_misc;
		logic [2:0] cs [3];
		cs = '{3'h6, 3'h0, 3'h3};
		@(posedge clk);
		ft_n <= 1'b0;
		ft_drv <= 1'b1;
		u_host.cyc(BEG_C, SEL, WNONE, 2'h2, 36'h0);
		repeat (2) begin
			u_host.cyc(SUSP, SEL, WNONE, 2'h2, 36'h0);
			#1 chk(dq, mem[2]);
		end
		@(posedge clk);
		oe_n <= 1'b1;
		#1 chk(36'(dq_oe), 36'h0);
		@(posedge clk);
		oe_n <= 1'b0;
		slp <= 1'b1;
		#1 chk(36'(dq_oe), 36'h0);
		@(posedge clk);
		slp_drv <= 1'b0;
		u_host.cyc(BEG_C, SEL, WNONE, 2'h2, 36'h0);
		u_host.cyc(SUSP, SEL, WNONE, 2'h2, 36'h0);
		#1 chk({dq_oe, dq}, {1'b1, mem[2]});
		foreach (cs[j]) begin
			u_host.cyc(BEG_C, SEL, WNONE, 2'h0, 36'h0);
			u_host.cyc(BEG_C, cs[j], WNONE, 2'h0, 36'h0);
			u_host.cyc(SUSP, cs[j], WNONE, 2'h0, 36'h0);
			#1 chk(36'(dq_oe), 36'h0);
		end
	endtask : t_misc
	initial begin
		#20000;
		fails++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reg;
		wr_burst(2'h2, 1'b0, WG, 4);
		wr_burst(2'h3, 1'b1, 6'h2a, 2);
		wr_burst(2'h1, 1'b0, 6'h0f, 1);
		t_read(2'h0, 1'b0, 1'b0, BEG_C);
		t_read(2'h1, 1'b1, 1'b1, BEG_P);
		t_misc;
		conclude;
	end
endmodule : ssbc_sram_test
`default_nettype wire
